// *** common/addr_gen_pkg.sv ***
// Constants for the program counter, return stack and banked data addressing block
package addr_gen_pkg;
   // =====================================================================
   // Program address space
   localparam int          PC_W           = 12;
   localparam logic [11:0] PC_RESET       = 12'h0fff;
   localparam int          PAGE_LSB       = 9;
   localparam int          PAGE_W         = 3;
   localparam int          STACK_DEPTH    = 8;
   // =====================================================================
   // Data address space
   localparam int          DATA_W         = 8;
   localparam int          FIELD_W        = 5;
   localparam logic [4:0]  REG_INDIRECT   = 5'h00;
   localparam logic [4:0]  REG_PC_LOW     = 5'h02;
   localparam logic [4:0]  REG_STATUS     = 5'h03;
   localparam logic [4:0]  REG_POINTER    = 5'h04;
   localparam int          FIELD_SEMI_BIT = 4;
   localparam int          STATUS_PAGE_LSB = 5;
   localparam int          BANK_SEL_LSB   = 4;
   localparam int          BANK_SEL_W     = 3;
   localparam int          BLOCK_BIT      = 7;
   localparam logic [7:0]  POINTER_RESET  = 8'h00;
   localparam logic [2:0]  PAGE_RESET     = 3'h0;
   // Data address mode
   typedef enum logic [1:0] {MODE_INDIRECT, MODE_DIRECT, MODE_SEMI} addr_mode_e;
endpackage : addr_gen_pkg

// *** rtl/addr_gen.sv ***
// Program counter, return stack and banked data address generator
`timescale 1ns/1ps
module addr_gen
#(
   parameter int STACK_N = addr_gen_pkg::STACK_DEPTH
)(
   input  wire logic                              i_core_clk,
   input  wire logic                              i_nrst,
   // Sequencing controls from instruction execute, one cycle per instruction
   input  wire logic                              i_step,
   input  wire logic                              i_jump,
   input  wire logic                              i_call,
   input  wire logic                              i_ret,
   input  wire logic [addr_gen_pkg::PC_W-1:0]     i_target,
   // Page and bank instructions
   input  wire logic                              i_page_load,
   input  wire logic [addr_gen_pkg::PAGE_W-1:0]   i_page_value,
   input  wire logic                              i_bank_load,
   input  wire logic [addr_gen_pkg::BANK_SEL_W-1:0] i_bank_value,
   // Register access from a data instruction
   input  wire logic [addr_gen_pkg::FIELD_W-1:0]  i_register_field,
   input  wire logic                              i_reg_write,
   input  wire logic [addr_gen_pkg::DATA_W-1:0]   i_reg_wdata,
   // Outputs
   output logic      [addr_gen_pkg::PC_W-1:0]     o_fetch_addr,
   output logic      [addr_gen_pkg::PAGE_W-1:0]   o_page_select_bits,
   output logic      [addr_gen_pkg::DATA_W-1:0]   o_data_pointer,
   output logic      [addr_gen_pkg::DATA_W-1:0]   o_reg_rdata,
   output logic                                   o_global_access,
   output logic      [addr_gen_pkg::DATA_W-1:0]   o_data_addr,
   output logic                                   o_stack_empty
);
   import addr_gen_pkg::*;

   // =====================================================================
   // Storage
   // Depth counter wide enough to hold a completely full stack
   localparam int      DEPTH_W = $clog2(STACK_N + 1);

   // Sequencing state
   logic [PC_W-1:0]    pc_q, pc_d;
   logic [PAGE_W-1:0]  page_q, page_d;
   logic [PC_W-1:0]    stack_q [STACK_N], stack_d [STACK_N];
   logic [DEPTH_W-1:0] depth_q, depth_d;
   logic               empty_q, empty_d;

   // Data pointer
   logic [DATA_W-1:0]  ptr_q, ptr_d;

   // Read path registers
   logic [DATA_W-1:0]  rdata_q, rdata_d;
   logic [DATA_W-1:0]  daddr_q, daddr_d;
   logic               glob_q, glob_d;

   // Decode results, combinational only
   addr_mode_e         mode;
   logic [DATA_W-1:0]  eff_addr;
   logic               eff_global;
   logic               pc_low_hit, ptr_hit;

   // =====================================================================
   // Address mode decode
   // Field zero names no register of its own; it only redirects through
   // the pointer, so it must be tested before the direct range
   always_comb
   begin
      if (i_register_field == REG_INDIRECT)
         mode = MODE_INDIRECT;
      else if (i_register_field[FIELD_SEMI_BIT])
         mode = MODE_SEMI;
      else
         mode = MODE_DIRECT;
   end

   // =====================================================================
   // Effective data address
   // The global bank is the only home of the special registers, so the
   // bank flag travels with the address to the data memory
   always_comb
   begin
      eff_addr   = '0;
      eff_global = 1'b0;
      case (mode)
         MODE_INDIRECT:
         begin
            // Pointers 00h-0Fh reach the global bank; bank 0 is out of
            // reach because its addresses coincide with the global ones
            eff_addr   = ptr_q;
            eff_global = (ptr_q[7:4] == 4'h0);
         end
         MODE_DIRECT:
         begin
            // The pointer plays no part here
            eff_addr   = {3'h0, i_register_field};
            eff_global = 1'b1;
         end
         MODE_SEMI:
         begin
            // Low pointer nibble is ignored; pointer bit 7 picks the block
            eff_addr   = {ptr_q[7:4], i_register_field[3:0]};
            eff_global = 1'b0;
         end
         default:
         begin
            eff_addr   = '0;
            eff_global = 1'b0;
         end
      endcase
      // Special registers live only in the global bank; 00h has no storage
      pc_low_hit = eff_global && (eff_addr[4:0] == REG_PC_LOW);
      ptr_hit    = eff_global && (eff_addr[4:0] == REG_POINTER);
   end

   // =====================================================================
   // Program counter and page field next state
   always_comb
   begin
      pc_d   = pc_q;
      page_d = page_q;
      // A page instruction only arms the upper bits for the next branch
      if (i_page_load)
         page_d = i_page_value;
      // Branches outrank a plain step: call, then return, then jump, then
      // a write to the counter low byte; only one of them takes effect
      if (i_call)
      begin
         // The target keeps its own bit 8; the page field gives the rest
         pc_d = {page_q, i_target[PAGE_LSB-1:0]};
      end
      else if (i_ret)
         pc_d = stack_q[0];
      else if (i_jump)
         pc_d = {page_q, i_target[PAGE_LSB-1:0]};
      else if (i_reg_write && pc_low_hit)
      begin
         // Bit 8 cannot be written, so a computed jump stays in the
         // lower half of the current page
         pc_d = {page_q, 1'b0, i_reg_wdata};
      end
      else if (i_step)
      begin
         // Plain binary count: page edges and the top address pass freely
         pc_d = PC_W'(pc_q + 12'h001);
      end
   end

   // =====================================================================
   // Return stack next state
   // The stack moves as a whole shift register, so no port into it exists
   // anywhere in the data address space
   always_comb
   begin
      depth_d = depth_q;
      for (int k = 0; k < STACK_N; k++)
         stack_d[k] = stack_q[k];
      if (i_call)
      begin
         // Newest return address on top; a call beyond the depth pushes
         // the oldest entry off the bottom without warning
         for (int k = STACK_N - 1; k > 0; k--)
            stack_d[k] = stack_q[k-1];
         stack_d[0] = PC_W'(pc_q + 12'h001);
         if (depth_q < DEPTH_W'(STACK_N))
            depth_d = DEPTH_W'(depth_q + 1'b1);
      end
      else if (i_ret)
      begin
         // Popping an empty stack repeats the bottom entry: there is no
         // underflow trap, so software must keep calls and returns paired
         for (int k = 0; k < STACK_N - 1; k++)
            stack_d[k] = stack_q[k+1];
         if (depth_q != '0)
            depth_d = DEPTH_W'(depth_q - 1'b1);
      end
      // Emptiness is registered so that the flag leaves a flip-flop
      empty_d = (depth_d == '0);
   end

   // =====================================================================
   // Data pointer next state
   // A full write beats a bank-select in the same cycle; bank-select never
   // touches bit 7 or the low nibble, so it cannot change block
   always_comb
   begin
      ptr_d = ptr_q;
      if (i_reg_write && ptr_hit)
         ptr_d = i_reg_wdata;
      else if (i_bank_load)
         ptr_d[BANK_SEL_LSB +: BANK_SEL_W] = i_bank_value;
   end

   // =====================================================================
   // Registered read data and access address
   // Only the counter low byte, the pointer and the page field live here;
   // every other address reads zero and is answered by the data memory,
   // which the execute logic addresses from the registered address
   always_comb
   begin
      rdata_d = '0;
      if (pc_low_hit)
         rdata_d = pc_q[7:0];
      else if (ptr_hit)
         rdata_d = ptr_q;
      else if (eff_global && (eff_addr[4:0] == REG_STATUS))
         rdata_d = {page_q, 5'h00};
      // Data memory registers are eight bits wide, one per address
      daddr_d = eff_addr;
      glob_d  = eff_global;
   end

   // =====================================================================
   // Program counter and page field registers
   // Reset starts execution at the top program word
   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         pc_q   <= PC_RESET;
         page_q <= PAGE_RESET;
      end
      else
      begin
         pc_q   <= pc_d;
         page_q <= page_d;
      end
   end

   // =====================================================================
   // Return stack registers
   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         depth_q <= '0;
         empty_q <= 1'b1;
         for (int k = 0; k < STACK_N; k++)
            stack_q[k] <= '0;
      end
      else
      begin
         depth_q <= depth_d;
         empty_q <= empty_d;
         for (int k = 0; k < STACK_N; k++)
            stack_q[k] <= stack_d[k];
      end
   end

   // =====================================================================
   // Data pointer register
   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         ptr_q <= POINTER_RESET;
      else
         ptr_q <= ptr_d;
   end

   // =====================================================================
   // Read path registers
   // The read answer and address follow the field one cycle later
   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rdata_q <= '0;
         daddr_q <= '0;
         glob_q  <= 1'b0;
      end
      else
      begin
         rdata_q <= rdata_d;
         daddr_q <= daddr_d;
         glob_q  <= glob_d;
      end
   end

   // =====================================================================
   // Outputs, all from flip-flops
   assign o_fetch_addr       = pc_q;
   assign o_page_select_bits = page_q;
   assign o_data_pointer     = ptr_q;
   assign o_reg_rdata        = rdata_q;
   assign o_data_addr        = daddr_q;
   assign o_global_access    = glob_q;
   // Every output is a register, so the execute logic sees no glitches
   assign o_stack_empty      = empty_q;
   // Data RAM itself sits with the execute logic, addressed by o_data_addr.
endmodule : addr_gen

// *** sim/addr_gen_checker.sv ***
// Port checker for the address generator
`timescale 1ns/1ps
module addr_gen_checker (
   input wire logic        i_core_clk,
   input wire logic        i_nrst,
   input wire logic        i_step,
   input wire logic        i_jump,
   input wire logic        i_call,
   input wire logic        i_ret,
   input wire logic [11:0] i_target,
   input wire logic        i_page_load,
   input wire logic        i_bank_load,
   input wire logic [2:0]  i_bank_value,
   input wire logic [4:0]  i_register_field,
   input wire logic        i_reg_write,
   input wire logic [11:0] o_fetch_addr,
   input wire logic [2:0]  o_page_select_bits,
   input wire logic [7:0]  o_data_pointer,
   input wire logic        o_global_access,
   input wire logic [7:0]  o_data_addr,
   input wire logic        o_stack_empty
);
   // ==========
   // Checks, with every branch source that outranks a step
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   wire logic wr_pc_low = i_reg_write && (i_register_field == 5'h02
      || (i_register_field == 5'h00 && o_data_pointer == 8'h02));
   wire logic wr_pointer = i_reg_write && (i_register_field == 5'h04
      || (i_register_field == 5'h00 && o_data_pointer == 8'h04));
   wire logic branch = i_call | i_ret | i_jump | wr_pc_low;
   property p_reset; !$past(i_nrst) |-> o_fetch_addr == 12'h0fff && o_stack_empty; endproperty
   a_reset: assert property (p_reset) else $error("reset state");
   property p_step; i_step && !branch |=> o_fetch_addr == 12'($past(o_fetch_addr) + 12'h001); endproperty
   a_step: assert property (p_step) else $error("step");
   property p_jump; i_jump && !i_call && !i_ret && !i_page_load
      |=> o_fetch_addr == {$past(o_page_select_bits), 9'($past(i_target))}; endproperty
   a_jump: assert property (p_jump) else $error("jump");
   property p_bank; i_bank_load && !wr_pointer
      |=> o_data_pointer == (($past(o_data_pointer) & 8'h8f) | {1'b0, $past(i_bank_value), 4'h0}); endproperty
   a_bank: assert property (p_bank) else $error("bank");
   property p_ind; i_register_field == 5'h00 |=> o_data_addr == $past(o_data_pointer)
      && o_global_access == ($past(o_data_pointer) < 8'h10); endproperty
   a_ind: assert property (p_ind) else $error("indirect");
   property p_dir; i_register_field inside {[5'h01:5'h0f]} |=> o_global_access
      && o_data_addr == 8'($past(i_register_field)); endproperty
   a_dir: assert property (p_dir) else $error("direct");
   property p_semi; i_register_field[4] |=> !o_global_access
      && o_data_addr == (($past(o_data_pointer) & 8'hf0) | 8'(4'($past(i_register_field)))); endproperty
   a_semi: assert property (p_semi) else $error("semi");
   property p_cr; i_call ##1 (i_ret && !i_call) |=> o_fetch_addr == 12'($past(o_fetch_addr, 2) + 12'h001); endproperty
   a_cr: assert property (p_cr) else $error("call return");
   c_cr: cover property (i_call ##1 i_ret);
   c_wrap: cover property (o_fetch_addr == 12'h0fff ##1 o_fetch_addr == 12'h0000);
   c_upper: cover property (i_register_field[4] && o_data_pointer[7]);
endmodule : addr_gen_checker

// *** sim/exec_model.sv ***
// Decode-stage model turning opcodes into address generator controls
`timescale 1ns/1ps
module exec_model (
   input  wire logic [2:0]  i_op,
   input  wire logic [12:0] i_arg,
   output logic             o_step,
   output logic             o_jump,
   output logic             o_call,
   output logic             o_ret,
   output logic             o_page_load,
   output logic             o_bank_load,
   output logic             o_reg_write,
   output logic [11:0]      o_target,
   output logic [2:0]       o_page_value,
   output logic [2:0]       o_bank_value,
   output logic [4:0]       o_register_field,
   output logic [7:0]       o_reg_wdata
);
   // One pulse per opcode; 7 is a plain register read
   assign o_step = i_op == 3'h0;
   assign o_jump = i_op == 3'h1;
   assign o_call = i_op == 3'h2;
   assign o_ret = i_op == 3'h3;
   assign o_page_load = i_op == 3'h4;
   assign o_bank_load = i_op == 3'h5;
   assign o_reg_write = i_op == 3'h6;
   // Operands overlap, so targets carry junk in bits 11:9
   assign o_target = i_arg[11:0];
   assign o_page_value = i_arg[2:0];
   assign o_bank_value = i_arg[2:0];
   assign o_register_field = i_arg[12:8];
   assign o_reg_wdata = i_arg[7:0];
endmodule : exec_model

// *** sim/tb.sv ***
// Directed bench for the address generator
`timescale 1ns/1ps
module tb;
   logic        i_core_clk = 1'b0;
   logic        i_nrst = 1'b0;
   logic [2:0]  op = 3'h7;
   logic [12:0] arg = 13'h0000;
   int          error_cnt = 0;
   int          n_compared = 0;
   logic        i_step, i_jump, i_call, i_ret, i_page_load, i_bank_load, i_reg_write, o_global_access, o_stack_empty;
   logic [11:0] i_target, o_fetch_addr;
   logic [2:0]  i_page_value, i_bank_value, o_page_select_bits;
   logic [4:0]  i_register_field;
   logic [7:0]  i_reg_wdata, o_data_pointer, o_reg_rdata, o_data_addr;
   always #12.5 i_core_clk = ~i_core_clk;
   exec_model u_model (.i_op(op), .i_arg(arg), .o_step(i_step), .o_jump(i_jump), .o_call(i_call), .o_ret(i_ret),
      .o_page_load(i_page_load), .o_bank_load(i_bank_load), .o_reg_write(i_reg_write), .o_target(i_target),
      .o_page_value(i_page_value), .o_bank_value(i_bank_value), .o_register_field(i_register_field),
      .o_reg_wdata(i_reg_wdata));
   addr_gen u_dut (.i_core_clk, .i_nrst, .i_step, .i_jump, .i_call, .i_ret, .i_target, .i_page_load, .i_page_value,
      .i_bank_load, .i_bank_value, .i_register_field, .i_reg_write, .i_reg_wdata, .o_fetch_addr,
      .o_page_select_bits, .o_data_pointer, .o_reg_rdata, .o_global_access, .o_data_addr, .o_stack_empty);
   // ==========
   // Compare, issue one instruction, close the run
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic run(input logic [2:0] o, input logic [12:0] a);
      @(posedge i_core_clk);
      op <= o;
      arg <= a;
      @(posedge i_core_clk);
      op <= 3'h7;
      #1;
   endtask : run
   task automatic stop_test();
      if (error_cnt == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   initial
   begin
      repeat (16) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      #1;
      chk(o_fetch_addr, 12'h0fff);
      chk(o_stack_empty, 12'h0001);
      run(0, 13'h0000);
      chk(o_fetch_addr, 12'h0000);
      run(1, 13'h03ff);
      run(0, 13'h0000);
      chk(o_fetch_addr, 12'h0200);
      for (int p = 0; p < 8; p++)
      begin
         run(4, 13'(p));
         chk(o_page_select_bits, 12'(p));
         run(1, 13'h1e45);
         chk(o_fetch_addr, {3'(p), 9'h045});
         run(7, 13'h0300);
         chk(o_reg_rdata, {4'h0, 3'(p), 5'h00});
      end
      run(6, 13'h02a5);
      run(7, 13'h0200);
      chk(o_reg_rdata, 12'h00a5);
      chk(o_fetch_addr, 12'h0ea5);
      run(1, 13'h01ff);
      run(0, 13'h0000);
      chk(o_fetch_addr, 12'h0000);
      run(4, 13'h0001);
      for (int k = 0; k < 8; k++)
         run(2, 13'(k));
      chk(o_stack_empty, 12'h0000);
      for (int k = 7; k >= 0; k--)
      begin
         run(3, 13'h0000);
         chk(o_fetch_addr, k > 0 ? 12'(12'h200 + k) : 12'h0001);
      end
      chk(o_stack_empty, 12'h0001);
      @(posedge i_core_clk);
      op <= 3'h2;
      arg <= 13'h0010;
      @(posedge i_core_clk);
      op <= 3'h3;
      run(7, 13'h0400);
      chk(o_fetch_addr, 12'h0002);
      run(6, 13'h04f0);
      run(7, 13'h0400);
      chk(o_reg_rdata, 12'h00f0);
      run(7, 13'h1300);
      chk({o_global_access, o_data_addr}, 12'h00f3);
      run(7, 13'h0000);
      chk({o_global_access, o_data_addr}, 12'h00f0);
      run(6, 13'h0405);
      run(7, 13'h0000);
      chk({o_global_access, o_data_addr}, 12'h0105);
      run(7, 13'h0f00);
      chk({o_global_access, o_data_addr}, 12'h010f);
      run(6, 13'h0485);
      run(5, 13'h1f03);
      chk(o_data_pointer, 12'h00b5);
      run(7, 13'h1f00);
      chk(o_data_addr, 12'h00bf);
      stop_test();
   end
endmodule : tb
bind addr_gen addr_gen_checker u_chk (.i_core_clk, .i_nrst, .i_step, .i_jump, .i_call, .i_ret, .i_target,
   .i_page_load, .i_bank_load, .i_bank_value, .i_register_field, .i_reg_write, .o_fetch_addr, .o_page_select_bits,
   .o_data_pointer, .o_global_access, .o_data_addr, .o_stack_empty);
